// ==== interrupt_source_logic.sv ====
// Interrupt sources, pending flags, priority and service sequence
`timescale 1ns/100ps
module interrupt_source_logic #(
  parameter int TICK128 = irq_src_pkg::TICK128_CYC,
  parameter int WAKE_PERIOD = irq_src_pkg::WAKE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire irq_src_pkg::axi_req_t axi_req,
  output irq_src_pkg::axi_rsp_t axi_rsp,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic ps2_data_line,
  input wire logic [1:0] cap_pin,
  input wire logic [15:0] gpio_pin,
  input wire logic [2:0] ep_txn_end,
  input wire logic [2:0] ep_acked,
  input wire logic spi_last_edge,
  input wire logic [7:0] spi_rx_byte,
  input wire logic instr_done,
  input wire logic cpu_ei,
  input wire logic cpu_di,
  output logic gie,
  output logic irq_sense,
  output logic svc_call,
  output logic svc_jump,
  output logic [15:0] svc_vector,
  output logic isr_start
);
  function automatic logic [4:0] first_one(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Pin synchronisers
  logic [20:0] sync1_ff, sync2_ff, sync3_ff;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end
    else
    begin
      sync1_ff <= {usb_dp, usb_dm, ps2_data_line, cap_pin, gpio_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  logic [15:0] gp_now, gp_old;
  logic [1:0] cap_now, cap_old;
  assign gp_now = sync2_ff[15:0];
  assign gp_old = sync3_ff[15:0];
  assign cap_now = sync2_ff[17:16];
  assign cap_old = sync3_ff[17:16];

  // Registers
  logic [7:0] p0_en_ff, p1_en_ff, p0_pol_ff, p1_pol_ff, gmask_ff, epmask_ff, ctrl_ff, spi_data_ff;
  localparam int NSRC_W = irq_src_pkg::NSRC;
  logic [NSRC_W-1:0] pend_ff;
  logic bus_flag_ff, transfer_complete_flag_ff, gie_ff;
  logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_idx_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_wr;
  assign do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
  function automatic logic wr_hit(input logic [7:0] idx);
    return do_wr && aw_idx_ff == idx && wstrb_ff[0];
  endfunction

  // AXI write channel
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      aw_idx_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bresp_ff <= irq_src_pkg::RESP_OKAY;
    end
    else
    begin
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        aw_have_ff <= 1'b1;
        aw_idx_ff <= axi_req.awaddr[11:2] > 10'h0ff ? 8'hff : axi_req.awaddr[9:2];
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        w_have_ff <= 1'b1;
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
      if (do_wr)
      begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (aw_idx_ff inside {irq_src_pkg::IDX_P0_EN, irq_src_pkg::IDX_P1_EN, irq_src_pkg::IDX_P0_POL,
            irq_src_pkg::IDX_P1_POL, irq_src_pkg::IDX_GIE_MASK, irq_src_pkg::IDX_EP_MASK,
            irq_src_pkg::IDX_CTRL, irq_src_pkg::IDX_FLAGS})
        begin
          bresp_ff <= irq_src_pkg::RESP_OKAY;
        end
        else
        begin
          bresp_ff <= irq_src_pkg::RESP_SLVERR;
        end
      end
      else if (bvalid_ff && axi_req.bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Writable registers; acknowledge never touches pin enables
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      p0_en_ff <= irq_src_pkg::RST_BYTE;
      p1_en_ff <= irq_src_pkg::RST_BYTE;
      p0_pol_ff <= irq_src_pkg::RST_BYTE;
      p1_pol_ff <= irq_src_pkg::RST_BYTE;
      gmask_ff <= irq_src_pkg::RST_BYTE;
      epmask_ff <= irq_src_pkg::RST_BYTE;
      ctrl_ff <= irq_src_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_hit(irq_src_pkg::IDX_P0_EN)) p0_en_ff <= wdata_ff[7:0];
      if (wr_hit(irq_src_pkg::IDX_P1_EN)) p1_en_ff <= wdata_ff[7:0];
      if (wr_hit(irq_src_pkg::IDX_P0_POL)) p0_pol_ff <= wdata_ff[7:0];
      if (wr_hit(irq_src_pkg::IDX_P1_POL)) p1_pol_ff <= wdata_ff[7:0];
      if (wr_hit(irq_src_pkg::IDX_GIE_MASK)) gmask_ff <= wdata_ff[7:0];
      if (wr_hit(irq_src_pkg::IDX_EP_MASK)) epmask_ff <= {5'h00, wdata_ff[2:0]};
      if (wr_hit(irq_src_pkg::IDX_CTRL)) ctrl_ff <= {3'h0, wdata_ff[4:0]};
    end
  end

  // AXI read channel; pin enables and polarities are write-only
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= irq_src_pkg::RESP_OKAY;
    end
    else if (axi_req.arvalid && axi_rsp.arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= irq_src_pkg::RESP_OKAY;
      rdata_ff <= '0;
      if (axi_req.araddr[11:2] > 10'h0ff)
        rresp_ff <= irq_src_pkg::RESP_SLVERR;
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_GIE_MASK)
        rdata_ff <= {24'h00_0000, gmask_ff};
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_EP_MASK)
        rdata_ff <= {24'h00_0000, epmask_ff};
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_CTRL)
        rdata_ff <= {24'h00_0000, ctrl_ff};
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_STATUS)
        rdata_ff <= {20'h0_0000, gie_ff, pend_ff};
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_FLAGS)
        rdata_ff <= {30'h0000_0000, transfer_complete_flag_ff, bus_flag_ff};
      else if (axi_req.araddr[9:2] == irq_src_pkg::IDX_SPI_DATA)
        rdata_ff <= {24'h00_0000, spi_data_ff};
      else if (!(axi_req.araddr[9:2] inside {irq_src_pkg::IDX_P0_EN, irq_src_pkg::IDX_P1_EN,
          irq_src_pkg::IDX_P0_POL, irq_src_pkg::IDX_P1_POL}))
        rresp_ff <= irq_src_pkg::RESP_SLVERR;
    end
    else if (rvalid_ff && axi_req.rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end
  always_comb
  begin
    axi_rsp.awready = !aw_have_ff && !bvalid_ff;
    axi_rsp.wready = !w_have_ff && !bvalid_ff;
    axi_rsp.bvalid = bvalid_ff;
    axi_rsp.bresp = bresp_ff;
    axi_rsp.arready = !rvalid_ff;
    axi_rsp.rvalid = rvalid_ff;
    axi_rsp.rdata = rdata_ff;
    axi_rsp.rresp = rresp_ff;
  end

  // Free-running timebase
  logic [15:0] tick_cnt_ff;
  logic [2:0] ms_cnt_ff;
  logic tick128, tick1ms;
  assign tick128 = tick_cnt_ff == 16'(TICK128 - 1);
  assign tick1ms = tick128 && ms_cnt_ff == 3'(irq_src_pkg::MS_RATIO - 1);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tick_cnt_ff <= '0;
      ms_cnt_ff <= '0;
    end
    else
    begin
      tick_cnt_ff <= tick128 ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (tick128) ms_cnt_ff <= ms_cnt_ff + 3'h1;
    end
  end

  // Bus reset / PS/2 activity qualifier
  logic bus_cond, bus_evt;
  logic [1:0] qual_cnt_ff;
  assign bus_cond = ctrl_ff[irq_src_pkg::CT_BUS_SEL] ? !sync2_ff[18] : !sync2_ff[20] && !sync2_ff[19];
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      qual_cnt_ff <= '0;
    else if (!bus_cond)
      qual_cnt_ff <= '0;
    else if (tick128 && qual_cnt_ff != 2'(irq_src_pkg::QUAL_TICKS))
      qual_cnt_ff <= qual_cnt_ff + 2'h1;
  end
  always_comb
  begin
    if (ctrl_ff[irq_src_pkg::CT_BUS_SEL])
      bus_evt = bus_cond && tick128 && qual_cnt_ff == 2'(irq_src_pkg::QUAL_TICKS - 1);
    else
      bus_evt = !bus_cond && qual_cnt_ff == 2'(irq_src_pkg::QUAL_TICKS);
  end

  // GPIO edge and lock
  logic [15:0] pin_en, pin_pol, trig;
  logic lock_ff, gpio_evt, release_now;
  logic [3:0] lock_pin_ff;
  logic [4:0] trig_first;
  assign trig_first = first_one(trig);
  assign pin_en = {p1_en_ff, p0_en_ff};
  assign pin_pol = {p1_pol_ff, p0_pol_ff};
  assign trig = ((gp_now & ~gp_old & pin_pol) | (~gp_now & gp_old & ~pin_pol))
    & pin_en & {16{gmask_ff[irq_src_pkg::GM_GPIO]}};
  assign release_now = gp_now[lock_pin_ff] != pin_pol[lock_pin_ff] || !pin_en[lock_pin_ff];
  assign gpio_evt = !lock_ff && |trig;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lock_ff <= 1'b0;
      lock_pin_ff <= '0;
    end
    else if (gpio_evt)
    begin
      lock_ff <= 1'b1;
      lock_pin_ff <= trig_first[3:0];
    end
    else if (lock_ff && release_now)
    begin
      lock_ff <= 1'b0;
    end
  end

  // Capture edges, independent of GPIO path
  logic [1:0] cap_evt;
  assign cap_evt[0] = (cap_now[0] && !cap_old[0] && ctrl_ff[irq_src_pkg::CT_CAPA_RISE])
    || (!cap_now[0] && cap_old[0] && ctrl_ff[irq_src_pkg::CT_CAPA_FALL]);
  assign cap_evt[1] = (cap_now[1] && !cap_old[1] && ctrl_ff[irq_src_pkg::CT_CAPB_RISE])
    || (!cap_now[1] && cap_old[1] && ctrl_ff[irq_src_pkg::CT_CAPB_FALL]);

  // Wake-up timer
  logic [23:0] wake_cnt_ff;
  logic wake_evt;
  assign wake_evt = gmask_ff[irq_src_pkg::GM_WAKE] && wake_cnt_ff == 24'(WAKE_PERIOD - 1);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wake_cnt_ff <= '0;
    else if (wr_hit(irq_src_pkg::IDX_GIE_MASK) && !wdata_ff[irq_src_pkg::GM_WAKE])
      wake_cnt_ff <= '0;
    else if (gmask_ff[irq_src_pkg::GM_WAKE])
      wake_cnt_ff <= wake_evt ? 24'h00_0000 : wake_cnt_ff + 24'h00_0001;
  end

  // Pending flags and service sequence
  logic [NSRC_W-1:0] set_vec, en_vec, req, clr_vec;
  logic [4:0] take_idx;
  logic svc_take;
  irq_src_pkg::svc_state_t state_ff;
  logic [3:0] svc_cnt_ff;
  logic [15:0] vector_ff;
  assign set_vec = {wake_evt, gpio_evt, cap_evt, spi_last_edge, ep_txn_end & ep_acked,
    tick1ms, tick128, bus_evt};
  assign en_vec = {gmask_ff[7:3], epmask_ff[2:0], gmask_ff[2:0]};
  assign req = pend_ff & en_vec;
  assign take_idx = first_one({5'h00, req});
  assign svc_take = state_ff == irq_src_pkg::SVC_IDLE && gie_ff && instr_done && |req;
  always_comb
  begin
    clr_vec = '0;
    if (svc_take) clr_vec[take_idx[3:0]] = 1'b1;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pend_ff <= '0;
    else
      pend_ff <= (pend_ff & ~clr_vec) | set_vec;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      gie_ff <= 1'b0;
    else if (svc_take || cpu_di)
      gie_ff <= 1'b0;
    else if (cpu_ei)
      gie_ff <= 1'b1;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bus_flag_ff <= 1'b0;
      transfer_complete_flag_ff <= 1'b0;
      spi_data_ff <= '0;
    end
    else
    begin
      bus_flag_ff <= bus_evt || (bus_flag_ff && !(wr_hit(irq_src_pkg::IDX_FLAGS) && wdata_ff[0]));
      transfer_complete_flag_ff <= spi_last_edge || (transfer_complete_flag_ff && !(wr_hit(irq_src_pkg::IDX_FLAGS) && wdata_ff[1]));
      if (spi_last_edge) spi_data_ff <= spi_rx_byte;
    end
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= irq_src_pkg::SVC_IDLE;
      svc_cnt_ff <= '0;
      vector_ff <= '0;
    end
    else
    begin
      case (state_ff)
        irq_src_pkg::SVC_IDLE:
        begin
          if (svc_take)
          begin
            state_ff <= irq_src_pkg::SVC_CALL;
            svc_cnt_ff <= 4'(irq_src_pkg::CALL_CYC - 1);
            vector_ff <= {10'h000, take_idx + 5'h01, 1'b0};
          end
        end
        irq_src_pkg::SVC_CALL:
        begin
          svc_cnt_ff <= svc_cnt_ff - 4'h1;
          if (svc_cnt_ff == 4'h0)
          begin
            state_ff <= irq_src_pkg::SVC_JUMP;
            svc_cnt_ff <= 4'(irq_src_pkg::JMP_CYC - 1);
          end
        end
        irq_src_pkg::SVC_JUMP:
        begin
          svc_cnt_ff <= svc_cnt_ff - 4'h1;
          if (svc_cnt_ff == 4'h0) state_ff <= irq_src_pkg::SVC_IDLE;
        end
        default: state_ff <= irq_src_pkg::SVC_IDLE;
      endcase
    end
  end
  assign gie = gie_ff;
  assign irq_sense = |req;
  assign svc_call = state_ff == irq_src_pkg::SVC_CALL;
  assign svc_jump = state_ff == irq_src_pkg::SVC_JUMP;
  assign svc_vector = vector_ff;
  assign isr_start = svc_jump && svc_cnt_ff == 4'h0;

  // Checks
  sequence s_take;
    svc_take;
  endsequence
  sequence s_call_jump;
    svc_call [*8] ##1 svc_call ##1 svc_call ##1 svc_jump [*5];
  endsequence
  AST_LATENCY: assert property (@(posedge clock) disable iff (!rst_n) s_take |=> s_call_jump ##0 isr_start)
    else $error("service start not at call plus jump");
  AST_GIE_CLR: assert property (@(posedge clock) disable iff (!rst_n) s_take |=> !gie_ff)
    else $error("global enable kept on service");
  AST_PRIO: assert property (@(posedge clock) disable iff (!rst_n) svc_take && req[0] |=> svc_vector == 16'h0002)
    else $error("bus vector not taken first");
  AST_VEC: assert property (@(posedge clock) disable iff (!rst_n)
    svc_call |-> svc_vector >= 16'h0002 && svc_vector <= 16'h0016 && !svc_vector[0])
    else $error("vector out of table");
  AST_GPIO_LOCK: assert property (@(posedge clock) disable iff (!rst_n)
    lock_ff && !release_now && !pend_ff[irq_src_pkg::PD_GPIO]
    |=> lock_ff && $stable(lock_pin_ff) && !pend_ff[irq_src_pkg::PD_GPIO])
    else $error("second pin interrupt while held");
  AST_GPIO_EN: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pend_ff[irq_src_pkg::PD_GPIO]) |-> $past(gmask_ff[irq_src_pkg::GM_GPIO]))
    else $error("pin interrupt without main enable");
  AST_SPI: assert property (@(posedge clock) disable iff (!rst_n)
    spi_last_edge |=> pend_ff[irq_src_pkg::PD_SPI] && transfer_complete_flag_ff && spi_data_ff == $past(spi_rx_byte))
    else $error("spi byte end not flagged");
  AST_EP_NOACK: assert property (@(posedge clock) disable iff (!rst_n)
    ep_txn_end[0] && !ep_acked[0] && !pend_ff[irq_src_pkg::PD_EP0] |=> !pend_ff[irq_src_pkg::PD_EP0])
    else $error("endpoint flagged without ack");
  AST_WAKE_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    wr_hit(irq_src_pkg::IDX_GIE_MASK) && !wdata_ff[irq_src_pkg::GM_WAKE] |=> wake_cnt_ff == 24'h00_0000 [*2])
    else $error("wake timer not cleared");
endmodule

// ==== irq_src_pkg.sv ====
// Package: constants and carriers of the interrupt source logic
package irq_src_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T128_NS = 128000;
  localparam int T1MS_NS = 1024000;
  localparam int TICK128_CYC = T128_NS / CLK_PERIOD_NS;
  localparam int MS_RATIO = T1MS_NS / T128_NS;
  localparam int CALL_CYC = 10;
  localparam int JMP_CYC = 5;
  localparam int WAKE_CYC = 100000;
  localparam int QUAL_TICKS = 2;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_P0_EN = 8'h04;
  localparam logic [7:0] IDX_P1_EN = 8'h05;
  localparam logic [7:0] IDX_P0_POL = 8'h06;
  localparam logic [7:0] IDX_P1_POL = 8'h07;
  localparam logic [7:0] IDX_GIE_MASK = 8'h20;
  localparam logic [7:0] IDX_EP_MASK = 8'h21;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_FLAGS = 8'h32;
  localparam logic [7:0] IDX_SPI_DATA = 8'h33;
  // Global mask bits
  localparam int GM_GPIO = 6;
  localparam int GM_WAKE = 7;
  // Control bits
  localparam int CT_BUS_SEL = 0;
  localparam int CT_CAPA_RISE = 1;
  localparam int CT_CAPA_FALL = 2;
  localparam int CT_CAPB_RISE = 3;
  localparam int CT_CAPB_FALL = 4;
  // Pending bit positions, vector number minus one
  localparam int PD_BUS = 0;
  localparam int PD_T128 = 1;
  localparam int PD_T1MS = 2;
  localparam int PD_EP0 = 3;
  localparam int PD_SPI = 6;
  localparam int PD_CAPA = 7;
  localparam int PD_CAPB = 8;
  localparam int PD_GPIO = 9;
  localparam int PD_WAKE = 10;
  localparam int NSRC = 11;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SVC_IDLE = 2'b00, SVC_CALL = 2'b01, SVC_JUMP = 2'b11} svc_state_t;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [31:0] araddr; logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axi_rsp_t;
endpackage

// ==== cpu_core_model.sv ====
// CPU core model: instruction pacing and service timing capture
`timescale 1ns/100ps
module cpu_core_model #(
  parameter int INSTR_LEN = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic instr_done,
  input wire logic gie,
  input wire logic irq_sense,
  input wire logic svc_call,
  input wire logic svc_jump,
  input wire logic [15:0] svc_vector,
  input wire logic isr_start,
  output logic [7:0] lat_ff,
  output logic [7:0] ncall_ff,
  output logic [15:0] vec_ff,
  output logic [7:0] nsvc_ff
);
  logic [3:0] phase_ff;
  logic run_ff;
  logic [7:0] cnt_ff;
  // Last cycle of a multi-cycle instruction
  assign instr_done = (phase_ff == 4'(INSTR_LEN - 1));
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      phase_ff <= 4'h0;
      run_ff <= 1'h0;
      cnt_ff <= 8'h00;
      lat_ff <= 8'h00;
      ncall_ff <= 8'h00;
      vec_ff <= 16'h0000;
      nsvc_ff <= 8'h00;
    end
    else
    begin
      phase_ff <= instr_done ? 4'h0 : phase_ff + 4'h1;
      if (gie && irq_sense && instr_done && !svc_call && !svc_jump && !run_ff)
      begin
        run_ff <= 1'h1;
        cnt_ff <= 8'h01;
        ncall_ff <= 8'h00;
      end
      else if (run_ff)
      begin
        cnt_ff <= cnt_ff + 8'h01;
        ncall_ff <= ncall_ff + {7'h0, svc_call};
      end
      if (run_ff && isr_start)
      begin
        run_ff <= 1'h0;
        lat_ff <= cnt_ff;
        vec_ff <= svc_vector;
        nsvc_ff <= nsvc_ff + 8'h01;
      end
    end
  end
endmodule

// ==== tb.sv ====
// Testbench: register access, event stimulus and service checks
`timescale 1ns/100ps
module tb;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  irq_src_pkg::axi_req_t req;
  irq_src_pkg::axi_rsp_t rsp;
  logic usb_dp = 1'h1;
  logic usb_dm = 1'h0;
  logic ps2 = 1'h1;
  logic [1:0] cap = 2'h0;
  logic [15:0] gpio = 16'h0100;
  logic [2:0] ep_end = 3'h0;
  logic [2:0] ep_ack = 3'h0;
  logic spi_edge = 1'h0;
  logic [7:0] spi_byte = 8'h00;
  logic ei = 1'h0;
  logic instr_done, gie, irq_sense, svc_call, svc_jump, isr_start;
  logic [15:0] svc_vector, vec;
  logic [7:0] lat, ncall, nsvc;
  int bad_count = 0;
  int tests_run = 0;
  localparam logic [1:0] ok = irq_src_pkg::RESP_OKAY;
  localparam logic [1:0] err = irq_src_pkg::RESP_SLVERR;
  localparam logic [7:0] i_en0 = irq_src_pkg::IDX_P0_EN;
  localparam logic [7:0] i_en1 = irq_src_pkg::IDX_P1_EN;
  localparam logic [7:0] i_pol0 = irq_src_pkg::IDX_P0_POL;
  localparam logic [7:0] i_msk = irq_src_pkg::IDX_GIE_MASK;
  localparam logic [7:0] i_ep = irq_src_pkg::IDX_EP_MASK;
  localparam logic [7:0] i_ctl = irq_src_pkg::IDX_CTRL;
  localparam logic [7:0] i_st = irq_src_pkg::IDX_STATUS;
  localparam logic [7:0] i_fl = irq_src_pkg::IDX_FLAGS;
  localparam logic [7:0] i_spi = irq_src_pkg::IDX_SPI_DATA;
  always #5 clock = ~clock;
  interrupt_source_logic #(.TICK128(16), .WAKE_PERIOD(20)) uut (.clock(clock), .rst_n(rst_n),
    .axi_req(req), .axi_rsp(rsp), .usb_dp(usb_dp), .usb_dm(usb_dm), .ps2_data_line(ps2),
    .cap_pin(cap), .gpio_pin(gpio), .ep_txn_end(ep_end), .ep_acked(ep_ack), .spi_last_edge(spi_edge),
    .spi_rx_byte(spi_byte), .instr_done(instr_done), .cpu_ei(ei), .cpu_di(1'h0), .gie(gie),
    .irq_sense(irq_sense), .svc_call(svc_call), .svc_jump(svc_jump), .svc_vector(svc_vector),
    .isr_start(isr_start));
  cpu_core_model cpu (.clock(clock), .rst_n(rst_n), .instr_done(instr_done), .gie(gie),
    .irq_sense(irq_sense), .svc_call(svc_call), .svc_jump(svc_jump), .svc_vector(svc_vector),
    .isr_start(isr_start), .lat_ff(lat), .ncall_ff(ncall), .vec_ff(vec), .nsvc_ff(nsvc));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    int n;
    r = 2'h3;
    n = 0;
    req.awvalid <= 1'h1;
    req.awaddr <= {22'h0, i, 2'h0};
    req.wvalid <= 1'h1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    while (n < 100)
    begin
      @(posedge clock);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid)
      begin
        r = rsp.bresp;
        n = 1000;
      end
    end
    chk("bresp", {14'h0, er}, {14'h0, r});
  endtask
  task automatic rd(input logic [7:0] i, input logic [11:0] m, input logic [11:0] e, input logic [1:0] er);
    logic [11:0] d;
    logic [1:0] r;
    int n;
    d = 12'hfff;
    r = 2'h3;
    n = 0;
    req.arvalid <= 1'h1;
    req.araddr <= {22'h0, i, 2'h0};
    while (n < 100)
    begin
      @(posedge clock);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid)
      begin
        d = rsp.rdata[11:0];
        r = rsp.rresp;
        n = 1000;
      end
    end
    chk("rresp", {14'h0, er}, {14'h0, r});
    chk("rdata", {4'h0, e}, {4'h0, d & m});
  endtask
  // Enable, wait for the model to see the routine start
  task automatic svc(input logic [15:0] v);
    logic [7:0] k;
    int n;
    k = nsvc;
    n = 0;
    ei <= 1'h1;
    @(posedge clock);
    ei <= 1'h0;
    while (nsvc == k && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    chk("svc_done", 16'h0001, {15'h0, nsvc != k});
    chk("vector", v, vec);
    chk("latency", 16'(irq_src_pkg::CALL_CYC + irq_src_pkg::JMP_CYC), {8'h0, lat});
    chk("call", 16'(irq_src_pkg::CALL_CYC), {8'h0, ncall});
    chk("gie", 16'h0000, {15'h0, gie});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(5000);
    bad_count++;
    summarize;
  end
  initial
  begin
    req = '0;
    req.bready = 1'h1;
    req.rready = 1'h1;
    cyc(8);
    rst_n <= 1'h1;
    rd(i_st, 12'h807, 12'h000, ok);
    rd(i_msk, 12'h0ff, 12'h000, ok);
    rd(i_ep, 12'h007, 12'h000, ok);
    rd(8'h40, 12'hfff, 12'h000, err);
    wr(8'h40, 8'h01, err);
    wr(i_st, 8'h01, err);
    wr(i_msk, 8'ha5, ok);
    rd(i_msk, 12'h0ff, 12'h0a5, ok);
    rd(i_pol0, 12'h0ff, 12'h000, ok);
    wr(i_msk, 8'h00, ok);
    cyc(10);
    rd(i_st, 12'h006, 12'h002, ok);
    cyc(110);
    rd(i_st, 12'h006, 12'h006, ok);
    wr(i_msk, 8'h06, ok);
    svc(16'h0004);
    wr(i_msk, 8'h00, ok);
    $display("test timers done");
    for (int e = 0; e < 3; e++)
    begin
      ep_end <= 3'(1 << e);
      @(posedge clock);
      ep_end <= 3'h0;
      cyc(2);
      rd(i_st, 12'h038, 12'((8 << e) - 8), ok);
      ep_end <= 3'(1 << e);
      ep_ack <= 3'(1 << e);
      @(posedge clock);
      ep_end <= 3'h0;
      ep_ack <= 3'h0;
      cyc(2);
      rd(i_st, 12'h038, 12'((16 << e) - 8), ok);
    end
    wr(i_ep, 8'h07, ok);
    svc(16'h0008);
    svc(16'h000a);
    svc(16'h000c);
    wr(i_ep, 8'h00, ok);
    $display("test endpoints done");
    spi_edge <= 1'h1;
    spi_byte <= 8'h5a;
    @(posedge clock);
    spi_edge <= 1'h0;
    spi_byte <= 8'ha5;
    cyc(1);
    rd(i_spi, 12'h0ff, 12'h05a, ok);
    rd(i_fl, 12'h002, 12'h002, ok);
    rd(i_st, 12'h040, 12'h040, ok);
    wr(i_msk, 8'h08, ok);
    svc(16'h000e);
    $display("test spi done");
    // Capture A on rising edges, B on falling edges
    wr(i_ctl, 8'h12, ok);
    cap <= 2'h3;
    cyc(6);
    rd(i_st, 12'h380, 12'h080, ok);
    cap <= 2'h0;
    cyc(6);
    rd(i_st, 12'h380, 12'h180, ok);
    wr(i_msk, 8'h30, ok);
    svc(16'h0010);
    svc(16'h0012);
    wr(i_msk, 8'h00, ok);
    $display("test capture done");
    // Pin 0 rising, pin 8 falling by reset polarity, pin 2 disabled
    wr(i_en0, 8'h01, ok);
    wr(irq_src_pkg::IDX_P1_EN, 8'h01, ok);
    wr(i_pol0, 8'h01, ok);
    gpio <= 16'h0101;
    cyc(6);
    rd(i_st, 12'h200, 12'h000, ok);
    chk("irq_sense", 16'h0000, {15'h0, irq_sense});
    gpio <= 16'h0100;
    wr(i_msk, 8'h40, ok);
    gpio <= 16'h0104;
    cyc(6);
    rd(i_st, 12'h200, 12'h000, ok);
    gpio <= 16'h0105;
    cyc(6);
    rd(i_st, 12'h200, 12'h200, ok);
    chk("irq_sense", 16'h0001, {15'h0, irq_sense});
    svc(16'h0014);
    gpio <= 16'h0005;
    cyc(6);
    rd(i_st, 12'h200, 12'h000, ok);
    gpio <= 16'h0004;
    cyc(6);
    gpio <= 16'h0104;
    cyc(6);
    rd(i_st, 12'h200, 12'h000, ok);
    gpio <= 16'h0004;
    cyc(6);
    rd(i_st, 12'h200, 12'h200, ok);
    svc(16'h0014);
    wr(i_msk, 8'h00, ok);
    $display("test gpio done");
    wr(i_ctl, 8'h01, ok);
    ps2 <= 1'h0;
    cyc(10);
    ps2 <= 1'h1;
    cyc(4);
    rd(i_st, 12'h001, 12'h000, ok);
    ps2 <= 1'h0;
    cyc(40);
    rd(i_st, 12'h001, 12'h001, ok);
    rd(i_fl, 12'h001, 12'h001, ok);
    ps2 <= 1'h1;
    wr(i_msk, 8'h01, ok);
    svc(16'h0002);
    wr(i_ctl, 8'h00, ok);
    usb_dp <= 1'h0;
    ps2 <= 1'h0;
    cyc(40);
    rd(i_st, 12'h001, 12'h000, ok);
    usb_dp <= 1'h1;
    ps2 <= 1'h1;
    cyc(6);
    rd(i_st, 12'h001, 12'h001, ok);
    svc(16'h0002);
    $display("test bus event done");
    // Timer ticks stay masked while the wake timer runs
    wr(i_msk, 8'h80, ok);
    cyc(10);
    wr(i_msk, 8'h00, ok);
    wr(i_msk, 8'h80, ok);
    cyc(10);
    rd(i_st, 12'h400, 12'h000, ok);
    cyc(12);
    rd(i_st, 12'h400, 12'h400, ok);
    svc(16'h0016);
    wr(i_msk, 8'h00, ok);
    $display("test wake done");
    summarize;
  end
endmodule
